/* wtsi_pkg.sv */
package wtsi_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h60;
	localparam logic [7:0] OFS_MODE   = 8'h64;
	localparam logic [7:0] OFS_STATUS = 8'h70;
	localparam logic [7:0] OFS_IEN    = 8'h74;
	localparam logic [7:0] OFS_IDIS   = 8'h78;
	localparam logic [7:0] OFS_IMASK  = 8'h7C;
	localparam logic [7:0] OFS_COUNT  = 8'h80;
	localparam logic [7:0] OFS_CMPA   = 8'h84;
	localparam logic [7:0] OFS_CMPB   = 8'h88;
	localparam logic [7:0] OFS_CMPC   = 8'h8C;

	// Status, enable and mask bit positions
	localparam int B_WRAP = 0;
	localparam int B_MA   = 2;
	localparam int B_MB   = 3;
	localparam int B_MC   = 4;
	localparam int B_ETRG = 7;
	localparam int B_CLK  = 8;
	localparam int B_MIRA = 9;
	localparam int B_MIRB = 10;
	localparam int B_CHGB = 16;
	localparam int B_CHGA = 17;
	localparam int B_CHGK = 18;
	localparam logic [31:0] EVT_BITS = 32'h0007009D;
	localparam logic [31:0] CHG_BITS = 32'h00070000;

	// Control register bits
	localparam int C_CLKEN  = 0;
	localparam int C_CLKDIS = 1;
	localparam int C_SWTRG  = 2;

	// Mode register field positions
	localparam int M_CSRC  = 0;
	localparam int M_EDGE  = 8;
	localparam int M_SRC   = 10;
	localparam int M_TEN   = 12;
	localparam int M_PIN_A_MATCH_A_ACTION  = 16;
	localparam int M_PIN_A_MATCH_C_ACTION  = 18;
	localparam int M_PIN_A_EXT_EVENT_ACTION = 20;
	localparam int M_ASW   = 22;
	localparam logic [31:0] MODE_BITS = 32'h00FF1F01;

	// Reset values and counter limits
	localparam logic [31:0] MODE_RST = 32'h00000000;
	localparam logic [31:0] MASK_RST = 32'h00000000;
	localparam logic [15:0] CMP_RST  = 16'h0000;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;

	// Pin action codes
	typedef enum logic [1:0] {
		WTSI_ACT_NONE = 2'h0,
		WTSI_ACT_SET  = 2'h1,
		WTSI_ACT_CLR  = 2'h2,
		WTSI_ACT_TGL  = 2'h3
	} wtsi_act_e;

endpackage : wtsi_pkg

/* wtsi_sync2.sv */
`timescale 1ns/100ps
// Two-stage synchroniser, deliberately without reset
module wtsi_sync2 #(
	parameter int WIDTH = 3
) (
	// Clock
	input  wire logic             clk_i,
	// Asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o  <= meta;
	end

endmodule : wtsi_sync2

/* wtsi_pin_action.sv */
`timescale 1ns/100ps
// Next level of a waveform pin from four prioritised events
module wtsi_pin_action
	import wtsi_pkg::*;
(
	// Current pin level
	input  wire logic      level_i,
	// Action codes per event
	input  wire wtsi_act_e act_sw_i,
	input  wire wtsi_act_e act_ext_i,
	input  wire wtsi_act_e act_mc_i,
	input  wire wtsi_act_e act_ma_i,
	// Event strobes
	input  wire logic      hit_sw_i,
	input  wire logic      hit_ext_i,
	input  wire logic      hit_mc_i,
	input  wire logic      hit_ma_i,
	// Resulting level
	output logic           level_o
);

	// Apply one action code to a level
	function automatic logic apply_act(input wtsi_act_e act, input logic lvl);
		unique case (act)
			WTSI_ACT_NONE: apply_act = lvl;
			WTSI_ACT_SET:  apply_act = 1'b1;
			WTSI_ACT_CLR:  apply_act = 1'b0;
			WTSI_ACT_TGL:  apply_act = ~lvl;
		endcase
	endfunction : apply_act

	// Highest event that really acts wins; a "none" does not block lower ones
	always_comb begin
		if (hit_sw_i && act_sw_i != WTSI_ACT_NONE) begin
			level_o = apply_act(act_sw_i, level_i);
		end else if (hit_ext_i && act_ext_i != WTSI_ACT_NONE) begin
			level_o = apply_act(act_ext_i, level_i);
		end else if (hit_mc_i && act_mc_i != WTSI_ACT_NONE) begin
			level_o = apply_act(act_mc_i, level_i);
		end else if (hit_ma_i) begin
			level_o = apply_act(act_ma_i, level_i);
		end else begin
			level_o = level_i;
		end
	end

endmodule : wtsi_pin_action

/* wtsi_timer.sv */
`timescale 1ns/100ps
// Summary of operation
// - Counter passing from FFFF to 0000 sets the wrap flag.
// - Event flags stay set until the next status read.
// - Counter becoming equal to compare A sets the match A flag.
// - Counter becoming equal to compare B or C sets match B or match C flag.
// - External trigger flag set on selected edge of selected pin while enabled.
// - Pin A mirror bit follows the pin A level.
// - Pin B mirror bit follows the pin B level.
// - Mirror bits carry no defined value after reset.
// - Pin B change bit reads 0 after a change since last read, else 1.
// - Pin A change bit reads 0 after a change since last read, else 1.
// - External clock pin change bit reads 0 after a change, else 1.
// - Enable and disable registers act on ones, ignore zeros, status layout.
// - Mask register reads 1 per enabled source, status layout.
// - A set flag with its source enabled raises the interrupt request.
// - Counter register reads the live 16-bit count, maximum 65535.
// - A trigger loads 0000 at the next counter clock edge, not at once.
// - Compare A match sets, clears, toggles or keeps pin A per its field.
// - Status read clears event and change flags, not clock or mirror bits.
// - Action codes: 00 none, 01 set, 10 clear, 11 toggle.
// - Coinciding pin A actions: software, external, match C, then match A.
module wtsi_timer (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Waveform pin A
	input  wire logic                 waveform_pin_a_i,
	output logic                      waveform_pin_a_o,
	output logic                      waveform_pin_a_oe_o,
	// Waveform pin B
	input  wire logic                 waveform_pin_b_i,
	output logic                      waveform_pin_b_o,
	output logic                      waveform_pin_b_oe_o,
	// External clock pin
	input  wire logic                 external_clock_pin_i,
	// Channel interrupt request
	output logic                      irq_o
);

	import wtsi_pkg::*;

	logic [2:0]  pin_sync;
	logic [2:0]  pin_prev;
	logic [2:0]  pin_chg;
	logic        armed;
	logic [15:0] live_count;
	logic [15:0] compare_a_level;
	logic [15:0] cmp_b;
	logic [15:0] cmp_c;
	logic [31:0] mode;
	logic [31:0] evt;
	logic [31:0] mask;
	logic [31:0] evt_set;
	logic [31:0] next_evt;
	logic [31:0] status_view;
	logic [31:0] next_rdata;
	logic [31:0] wmask;
	logic        clk_run;
	logic        trig_pend;
	logic        moved;
	logic        next_pin_a;
	logic        req;
	logic        wr;
	logic        rd;
	logic        st_rd;
	logic        sw_trg;
	logic        trg_now;
	logic        trg_old;
	logic        ext_edge;
	logic        ext_clk_rise;
	logic        tick;
	logic        trig;
	logic        match_a;
	logic        match_b;
	logic        match_c;
	logic        wrap;

	// Byte enables widened to a bit mask
	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		sel_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : sel_mask

	// Edge test for the trigger edge select field
	function automatic logic edge_hit(input logic [1:0] sel, input logic old_l, input logic now_l);
		unique case (sel)
			2'h1:    edge_hit = ~old_l & now_l;
			2'h2:    edge_hit = old_l & ~now_l;
			2'h3:    edge_hit = old_l ^ now_l;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Pins enter here; sync stages have no reset so mirrors start undefined
	wtsi_sync2 #(
		.WIDTH (3)
	) u_sync (
		.clk_i (clk_i),
		.d_i   ({external_clock_pin_i, waveform_pin_b_i, waveform_pin_a_i}),
		.q_o   (pin_sync)
	);

	// Previous synced levels; change detection armed only after reset
	always_ff @(posedge clk_i) begin
		pin_prev <= pin_sync;
		if (rst_i) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end

	// Pin change and edge detection on synced levels
	assign pin_chg      = armed ? (pin_sync ^ pin_prev) : 3'h0;
	assign trg_now      = (mode[M_SRC +: 2] == 2'h0) ? pin_sync[1] : pin_sync[2];
	assign trg_old      = (mode[M_SRC +: 2] == 2'h0) ? pin_prev[1] : pin_prev[2];
	assign ext_edge     = armed & edge_hit(mode[M_EDGE +: 2], trg_old, trg_now);
	assign ext_clk_rise = armed & pin_sync[2] & ~pin_prev[2];

	// Counter clock: every cycle or rising external pin, gated by clock enable
	assign tick = clk_run & (mode[M_CSRC] ? ext_clk_rise : 1'b1);

	// Bus request decode; every request is answered one cycle later
	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr     = req & wb_we_i;
	assign rd     = req & ~wb_we_i;
	assign st_rd  = rd && (wb_adr_i == OFS_STATUS);
	assign wmask  = sel_mask(wb_sel_i);
	assign sw_trg = wr && (wb_adr_i == OFS_CTRL) && wmask[C_SWTRG] && wb_dat_i[C_SWTRG];

	// Software trigger always; external only with trigger enable
	assign trig = sw_trg | (ext_edge & mode[M_TEN]);

	// Compare hits are checked once the counter has just moved
	assign match_a = moved && (live_count == compare_a_level);
	assign match_b = moved && (live_count == cmp_b);
	assign match_c = moved && (live_count == cmp_c);
	assign wrap    = tick && !trig_pend && (live_count == CNT_MAX);

	// Wishbone acknowledge, single cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Counter clock enable; disable wins over enable in one write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_run <= 1'b0;
		end else if (wr && wb_adr_i == OFS_CTRL && wmask[C_CLKDIS] && wb_dat_i[C_CLKDIS]) begin
			clk_run <= 1'b0;
		end else if (wr && wb_adr_i == OFS_CTRL && wmask[C_CLKEN] && wb_dat_i[C_CLKEN]) begin
			clk_run <= 1'b1;
		end
	end

	// Trigger waits for the next counter clock edge, then loads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_pend  <= 1'b0;
			live_count <= CNT_ZERO;
			moved      <= 1'b0;
		end else begin
			trig_pend <= (trig_pend & ~tick) | trig;
			moved     <= tick;
			if (tick) begin
				live_count <= trig_pend ? CNT_ZERO : live_count + 16'h0001;
			end
		end
	end

	// Mode and compare registers, byte lanes honoured
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode            <= MODE_RST;
			compare_a_level <= CMP_RST;
			cmp_b           <= CMP_RST;
			cmp_c           <= CMP_RST;
		end else if (wr) begin
			unique case (wb_adr_i)
				OFS_MODE: mode <= (mode & ~(wmask & MODE_BITS)) | (wb_dat_i & wmask & MODE_BITS);
				OFS_CMPA: compare_a_level <= (compare_a_level & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				OFS_CMPB: cmp_b <= (cmp_b & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				OFS_CMPC: cmp_c <= (cmp_c & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				default: ;
			endcase
		end
	end

	// Interrupt mask: ones set or clear, zeros leave bits alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask <= MASK_RST;
		end else if (wr && wb_adr_i == OFS_IEN) begin
			mask <= mask | (wb_dat_i & wmask & EVT_BITS);
		end else if (wr && wb_adr_i == OFS_IDIS) begin
			mask <= mask & ~(wb_dat_i & wmask & EVT_BITS);
		end
	end

	// Sticky event sources in status layout
	always_comb begin
		evt_set         = 32'h00000000;
		evt_set[B_WRAP] = wrap;
		evt_set[B_MA]   = match_a;
		evt_set[B_MB]   = match_b;
		evt_set[B_MC]   = match_c;
		evt_set[B_ETRG] = ext_edge & mode[M_TEN];
		evt_set[B_CHGA] = pin_chg[0];
		evt_set[B_CHGB] = pin_chg[1];
		evt_set[B_CHGK] = pin_chg[2];
	end

	// A status read clears; a fresh event in the same cycle survives it
	assign next_evt = (evt & ~(st_rd ? EVT_BITS : 32'h00000000)) | evt_set;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt <= 32'h00000000;
		end else begin
			evt <= next_evt;
		end
	end

	// Change bits read inverted: 0 means a change was seen
	always_comb begin
		status_view         = (evt & EVT_BITS & ~CHG_BITS) | (~evt & CHG_BITS);
		status_view[B_CLK]  = clk_run;
		status_view[B_MIRA] = pin_sync[0];
		status_view[B_MIRB] = pin_sync[1];
	end

	// Read data selection; unmapped and write-only offsets read zero
	always_comb begin
		unique case (wb_adr_i)
			OFS_MODE:   next_rdata = mode;
			OFS_STATUS: next_rdata = status_view;
			OFS_IMASK:  next_rdata = mask;
			OFS_COUNT:  next_rdata = {16'h0000, live_count};
			OFS_CMPA:   next_rdata = {16'h0000, compare_a_level};
			OFS_CMPB:   next_rdata = {16'h0000, cmp_b};
			OFS_CMPC:   next_rdata = {16'h0000, cmp_c};
			default:    next_rdata = 32'h00000000;
		endcase
	end

	// Read data stands only while acknowledged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_dat_o <= rd ? next_rdata : 32'h00000000;
		end
	end

	// Pin A event arbitration
	wtsi_pin_action u_pin_a (
		.level_i   (waveform_pin_a_o),
		.act_sw_i  (wtsi_act_e'(mode[M_ASW +: 2])),
		.act_ext_i (wtsi_act_e'(mode[M_PIN_A_EXT_EVENT_ACTION +: 2])),
		.act_mc_i  (wtsi_act_e'(mode[M_PIN_A_MATCH_C_ACTION +: 2])),
		.act_ma_i  (wtsi_act_e'(mode[M_PIN_A_MATCH_A_ACTION +: 2])),
		.hit_sw_i  (sw_trg),
		.hit_ext_i (ext_edge),
		.hit_mc_i  (match_c),
		.hit_ma_i  (match_a),
		.level_o   (next_pin_a)
	);

	// Pin drivers; pin B is an input while it is the trigger source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			waveform_pin_a_o    <= 1'b0;
			waveform_pin_a_oe_o <= 1'b0;
			waveform_pin_b_o    <= 1'b0;
			waveform_pin_b_oe_o <= 1'b0;
		end else begin
			waveform_pin_a_o    <= next_pin_a;
			waveform_pin_a_oe_o <= 1'b1;
			waveform_pin_b_o    <= 1'b0;
			waveform_pin_b_oe_o <= (mode[M_SRC +: 2] != 2'h0);
		end
	end

	// Interrupt request, one cycle behind the flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(evt & mask);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_wrap_flag_set:
	assert property (wrap |=> evt[B_WRAP]) else $error("wrap flag not set");
	a_flag_stays_set:
	assert property (evt[B_MB] && !st_rd |=> evt[B_MB]) else $error("sticky flag lost");
	a_read_clears:
	assert property (st_rd && !match_a ##1 !match_a |-> !evt[B_MA]) else $error("flag survived read");
	a_match_a_set:
	assert property (moved && live_count == compare_a_level |=> evt[B_MA]) else $error("match A missed");
	a_match_c_set:
	assert property (moved && live_count == cmp_c |=> evt[B_MC]) else $error("match C missed");
	a_trig_gated:
	assert property ($rose(evt[B_ETRG]) |-> $past(mode[M_TEN])) else $error("trigger flag while disabled");
	a_mirror_a:
	assert property (##2 status_view[B_MIRA] == $past(waveform_pin_a_i, 2)) else $error("pin A mirror wrong");
	a_mirror_b:
	assert property (##2 status_view[B_MIRB] == $past(waveform_pin_b_i, 2)) else $error("pin B mirror wrong");
	a_change_a_low:
	assert property (pin_chg[0] |=> !status_view[B_CHGA]) else $error("pin A change not shown");
	a_mask_enable:
	assert property (wr && wb_adr_i == OFS_IEN && wb_sel_i[2] && wb_dat_i[B_CHGK] |=> mask[B_CHGK])
		else $error("mask bit not enabled");
	a_mask_zero_write:
	assert property (wr && wb_adr_i == OFS_IDIS && wb_dat_i == 32'h00000000 |=> $stable(mask))
		else $error("zero write changed mask");
	a_irq_follows:
	assert property ((evt & mask) != 32'h00000000 |=> irq_o) else $error("interrupt not raised");
	a_count_reload:
	assert property (tick && trig_pend |=> live_count == CNT_ZERO) else $error("counter not reloaded");
	a_trig_deferred:
	assert property (trig && !tick |=> trig_pend && $stable(live_count)) else $error("trigger acted at once");
	a_soft_set_pin:
	assert property (sw_trg && mode[M_ASW +: 2] == 2'h1 |=> waveform_pin_a_o) else $error("pin A not set");
	a_clock_off:
	assert property (wr && wb_adr_i == OFS_CTRL && wb_dat_i[C_CLKDIS] && wb_sel_i[0] |=> !status_view[B_CLK])
		else $error("clock status still on");

	c_wrap_seen: cover property (wrap ##1 evt[B_WRAP]);
	c_irq_raised: cover property ($rose(irq_o));
	c_ext_trigger: cover property (ext_edge && mode[M_TEN] ##[1:20] tick);
	c_status_read: cover property (st_rd && evt[B_MA]);

endmodule : wtsi_timer

/* tb_waveform_timer_status_irq.sv */
`timescale 1ns/100ps
module tb_waveform_timer_status_irq;
	import wtsi_pkg::*;

	// Design inputs, all given a value at time zero
	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic        wb_cyc_i    = 1'b0;
	logic        wb_stb_i    = 1'b0;
	logic        wb_we_i     = 1'b0;
	logic [7:0]  wb_adr_i    = 8'h00;
	logic [3:0]  wb_sel_i    = 4'hF;
	logic [31:0] wb_dat_i    = 32'h00000000;
	logic        pin_a_drv   = 1'b0;
	logic        pin_b_drv   = 1'b0;
	logic        ext_clk_drv = 1'b0;
	// Design outputs and resolved pin wires
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin_a_o;
	logic        pin_a_oe;
	logic        pin_b_o;
	logic        pin_b_oe;
	logic        irq_o;
	wire         pin_a_wire;
	wire         pin_b_wire;
	// Bench state
	int          mismatches = 0;
	int          cmp_count  = 0;
	logic [31:0] rd;
	logic [31:0] val;
	logic [31:0] mv;
	logic [31:0] exp_mask;
	logic        exp_pin;

	always #12.5 clk_i = ~clk_i;

	// Whoever enables drives the wire; the bench stands in otherwise
	assign pin_a_wire = pin_a_oe ? pin_a_o : pin_a_drv;
	assign pin_b_wire = pin_b_oe ? pin_b_o : pin_b_drv;

	wtsi_timer dut (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.wb_cyc_i             (wb_cyc_i),
		.wb_stb_i             (wb_stb_i),
		.wb_we_i              (wb_we_i),
		.wb_adr_i             (wb_adr_i),
		.wb_sel_i             (wb_sel_i),
		.wb_dat_i             (wb_dat_i),
		.wb_dat_o             (wb_dat_o),
		.wb_ack_o             (wb_ack_o),
		.waveform_pin_a_i     (pin_a_wire),
		.waveform_pin_a_o     (pin_a_o),
		.waveform_pin_a_oe_o  (pin_a_oe),
		.waveform_pin_b_i     (pin_b_wire),
		.waveform_pin_b_o     (pin_b_o),
		.waveform_pin_b_oe_o  (pin_b_oe),
		.external_clock_pin_i (ext_clk_drv),
		.irq_o                (irq_o)
	);

	// Closing verdict, also reached from any exhausted wait
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check32

	task automatic check1(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask : check1

	// Classic cycle: request held until ack is sampled, then released
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			check1("bus ack", 1'b1, wb_ack_o);
			report_and_stop();
		end
	endtask : wb_cycle

	task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
		wb_cycle(1'b1, adr, dat);
	endtask : wb_wr

	task automatic wb_rd(input logic [7:0] adr);
		wb_cycle(1'b0, adr, 32'h00000000);
	endtask : wb_rd

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// Next pin level for an action code
	function automatic logic act_next(input logic cur, input logic [1:0] code);
		case (code)
			2'h1: return 1'b1;
			2'h2: return 1'b0;
			2'h3: return ~cur;
			default: return cur;
		endcase
	endfunction : act_next

	initial begin
		rd = $urandom(36);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped place
		wb_rd(OFS_IMASK);
		check32("mask after reset", MASK_RST, rd);
		wb_rd(OFS_COUNT);
		check32("count after reset", {16'h0000, CNT_ZERO}, rd);
		wb_rd(OFS_STATUS);
		check32("status after reset", CHG_BITS, rd);
		check1("pin a drive enable", 1'b1, pin_a_oe);
		wb_wr(8'h90, $urandom());
		wb_rd(8'h90);
		check32("unmapped read", 32'h00000000, rd);
		// Enable and disable only act on ones
		exp_mask = MASK_RST;
		for (int i = 0; i < 4; i++) begin
			val = $urandom();
			wb_wr(OFS_IEN, val);
			exp_mask = exp_mask | (val & EVT_BITS);
			wb_rd(OFS_IMASK);
			check32("mask after enable", exp_mask, rd);
			val = $urandom();
			wb_wr(OFS_IDIS, val);
			exp_mask = exp_mask & ~val;
			wb_rd(OFS_IMASK);
			check32("mask after disable", exp_mask, rd);
		end
		wb_wr(OFS_IEN, 32'hFFFFFFFF);
		wb_wr(OFS_IDIS, 32'h00000000);
		wb_rd(OFS_IMASK);
		check32("mask after zero disable", EVT_BITS, rd);
		wb_wr(OFS_IDIS, 32'hFFFFFFFF);
		// Compare A keeps its 16 bits only
		val = $urandom();
		wb_wr(OFS_CMPA, val);
		wb_rd(OFS_CMPA);
		check32("compare a readback", {16'h0000, val[15:0]}, rd);
		// Every software action code on pin A
		exp_pin = pin_a_o;
		for (int i = 0; i < 8; i++) begin
			mv = 32'((i + 1) % 4) << M_ASW;
			wb_wr(OFS_MODE, mv);
			wb_wr(OFS_CTRL, 32'h1 << C_SWTRG);
			idle(4);
			exp_pin = act_next(exp_pin, mv[M_ASW+:2]);
			check1("pin a after action", exp_pin, pin_a_o);
		end
		idle(4);
		val = (32'h1 << B_MIRA) | (32'h1 << B_CHGA);
		wb_rd(OFS_STATUS);
		check32("pin a change", 32'(exp_pin) << B_MIRA, rd & val);
		wb_rd(OFS_STATUS);
		check32("pin a quiet", (32'(exp_pin) << B_MIRA) | (32'h1 << B_CHGA), rd & val);
		// Clock running survives status reads; count is live
		wb_wr(OFS_CTRL, 32'h1 << C_CLKEN);
		wb_rd(OFS_STATUS);
		check1("clock running", 1'b1, rd[B_CLK]);
		wb_rd(OFS_STATUS);
		check1("clock running kept", 1'b1, rd[B_CLK]);
		wb_rd(OFS_COUNT);
		val = rd;
		wb_rd(OFS_COUNT);
		check1("count advancing", 1'b1, rd > val);
		wb_wr(OFS_CTRL, 32'h1 << C_SWTRG);
		wb_rd(OFS_COUNT);
		check1("count restarted", 1'b1, rd < 32'h10);
		// Match A toggles pin A and flag clears on read
		wb_wr(OFS_CMPA, rd + 32'h30);
		wb_wr(OFS_MODE, 32'h3 << M_PIN_A_MATCH_A_ACTION);
		wb_rd(OFS_STATUS);
		exp_pin = act_next(pin_a_o, 2'h3);
		idle(60);
		check1("pin a on match", exp_pin, pin_a_o);
		wb_rd(OFS_STATUS);
		check1("match a flag", 1'b1, rd[B_MA]);
		wb_rd(OFS_STATUS);
		check1("match a cleared", 1'b0, rd[B_MA]);
		// Full wrap with the wrap source enabled
		wb_wr(OFS_IEN, 32'h1 << B_WRAP);
		for (int i = 0; i < 70000 && irq_o !== 1'b1; i++) begin
			@(posedge clk_i);
		end
		check1("irq after wrap", 1'b1, irq_o);
		if (irq_o !== 1'b1) begin
			report_and_stop();
		end
		// Wrap lands on zero, which hits B and C; compare A sits far away
		wb_rd(OFS_STATUS);
		check32("flags after wrap", 32'h00000019, rd & 32'h0000001D);
		idle(3);
		check1("irq after read", 1'b0, irq_o);
		wb_wr(OFS_IDIS, 32'hFFFFFFFF);
		// Every edge code on pin B as trigger source
		val = (32'h1 << B_ETRG) | (32'h1 << B_MIRB) | (32'h1 << B_CHGB);
		for (int e = 0; e < 5; e++) begin
			// Last pass: both edges selected but trigger enable low
			mv = (32'(e == 4 ? 3 : e) << M_EDGE) | (32'(e < 4) << M_TEN);
			wb_wr(OFS_MODE, mv);
			idle(6);
			wb_rd(OFS_STATUS);
			pin_b_drv <= 1'b1;
			idle(6);
			wb_rd(OFS_STATUS);
			check32("rise on pin b", (32'(mv[M_EDGE] & mv[M_TEN]) << B_ETRG) | (32'h1 << B_MIRB), rd & val);
			pin_b_drv <= 1'b0;
			idle(6);
			wb_rd(OFS_STATUS);
			check32("fall on pin b", 32'(mv[M_EDGE+1] & mv[M_TEN]) << B_ETRG, rd & val);
		end
		// External clock pin as count source and trigger; pin B turns output
		wb_wr(OFS_MODE, (32'h1 << M_CSRC) | (32'h1 << M_SRC) | (32'h1 << M_EDGE) | (32'h1 << M_TEN));
		wb_rd(OFS_STATUS);
		wb_rd(OFS_COUNT);
		val = rd;
		ext_clk_drv <= 1'b1;
		idle(6);
		check1("pin b enable", 1'b1, pin_b_oe);
		check1("pin b drive", 1'b0, pin_b_o);
		wb_rd(OFS_STATUS);
		check1("ext clock changed", 1'b0, rd[B_CHGK]);
		check1("ext clock trigger", 1'b1, rd[B_ETRG]);
		wb_rd(OFS_STATUS);
		check1("ext clock quiet", 1'b1, rd[B_CHGK]);
		// Trigger and tick coincide: count steps once, reload waits a tick
		wb_rd(OFS_COUNT);
		check32("count on ext clock", val + 32'h1, rd);
		ext_clk_drv <= 1'b0;
		idle(6);
		ext_clk_drv <= 1'b1;
		idle(6);
		wb_rd(OFS_COUNT);
		check32("count after ext trigger", 32'h00000000, rd);
		// Clock disable shows in the status
		wb_wr(OFS_CTRL, 32'h1 << C_CLKDIS);
		wb_rd(OFS_STATUS);
		check1("clock stopped", 1'b0, rd[B_CLK]);
		report_and_stop();
	end

endmodule : tb_waveform_timer_status_irq
